/* File: hw/sclk_top.sv */
// configuration, clip, calibration and lockout logic of the sensor path
//
// Chosen here: the plain strobed port.
`include "sclk_consts.svh"
`default_nettype none
module sclk_top (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic power_on,
   input wire logic [7:0] addr,
   input wire logic [23:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [23:0] rdata,
   output logic [15:0] bandwidth_hz,
   output logic [4:0] update_rate_khz,
   output logic pwm_mode,
   output logic [11:0] upper_clip_limit,
   output logic [11:0] lower_clip_limit,
   output logic [11:0] duty_midpoint,
   output logic cal_done,
   output logic lock_active,
   output logic access_rejected
);
   // stored words start blank like a fresh part; reset must not touch
   // them, so the blank value is given once at declaration
   logic [23:0] cfg_word = `SCLK_BLANK_WORD;
   logic [23:0] out_word = `SCLK_BLANK_WORD;
   // programmed flags: until the config word is first written, the factory limits apply
   logic upper_set = 1'b0;
   logic lower_set = 1'b0;
   logic lock_armed;
   // power-on pin synchroniser
   logic pwr_q1;
   logic pwr_q2;
   logic pwr_q3;
   logic pwr_seen;
   // calibration sequencer state
   sclk_pkg::sclk_state_type state;
   sclk_pkg::sclk_state_type next_state;

   // bandwidth in hz per code; reserved codes fall back to default
   // so an ill-advised code still gives a sane filter instead of a fault
   function automatic logic [15:0] bw_hz(input logic [2:0] c);
      unique case (c)
         3'h1: bw_hz = 16'h0FA0;
         3'h3: bw_hz = 16'h03E8;
         3'h4: bw_hz = 16'h01F4;
         3'h5: bw_hz = 16'h00FA;
         default: bw_hz = 16'h07D0;
      endcase
   endfunction : bw_hz

   // update rate in khz per code
   // kept beside bw_hz so the pair can never disagree on a code
   function automatic logic [4:0] rate_khz(input logic [2:0] c);
      unique case (c)
         3'h1: rate_khz = 5'h10;
         3'h3: rate_khz = 5'h04;
         3'h4: rate_khz = 5'h02;
         3'h5: rate_khz = 5'h01;
         default: rate_khz = 5'h08;
      endcase
   endfunction : rate_khz

   // linear clip step: code times step, monotonic by construction
   // the step size is a free choice; it only has to keep 63 steps in range
   function automatic logic [11:0] clip_off(input logic [5:0] c, input logic [11:0] s);
      clip_off = 12'(c * s);
   endfunction : clip_off

   // field decode
   // field positions live in the constants header
   wire [2:0] bw_code = cfg_word[`SCLK_BW_LSB +: 3];
   wire mode_bit = cfg_word[`SCLK_MODE_BIT];
   wire [5:0] clph = cfg_word[`SCLK_CLPH_LSB +: 6];
   wire [5:0] clpl = cfg_word[`SCLK_CLPL_LSB +: 6];
   wire cal_en = out_word[`SCLK_CAL_BIT];
   wire lock_bit = out_word[`SCLK_LOCK_BIT];
   // address decode
   wire hit_cfg = addr == `SCLK_ADDR_CFG;
   wire hit_out = addr == `SCLK_ADDR_OUT;
   wire hit_stat = addr == `SCLK_ADDR_STAT;
   // a locked part drops every strobe; access_rejected tells the programmer
   wire wr_ok = wr_stb && !lock_active;
   wire rd_ok = rd_stb && !lock_active;
   // power-up event once per reset, from the two settled flops only
   wire pwr_up_edge = pwr_q3 && pwr_q2 && !pwr_seen;
   // clip limits; a field never written falls back to the factory pair
   wire [11:0] next_upper = upper_set ?
      (`SCLK_UPPER_MAX - clip_off(clph, `SCLK_UPPER_STEP)) : `SCLK_FACT_UPPER;
   wire [11:0] next_lower = lower_set ?
      (`SCLK_LOWER_MIN + clip_off(clpl, `SCLK_LOWER_STEP)) : `SCLK_FACT_LOWER;
   // half the span added to the floor: no carry out of 12 bits is possible
   wire [11:0] cal_mid = lower_clip_limit + 12'((upper_clip_limit - lower_clip_limit) >> 1);
   // read-only status view of the flags for the programmer
   wire [23:0] stat_word = {19'h0_0000, cal_done, lock_armed, lock_active, upper_set, lower_set};
   // read mux: a refused or unmapped read returns zero
   wire [23:0] next_rdata = !rd_ok ? 24'h00_0000 :
      hit_cfg ? cfg_word : hit_out ? out_word : hit_stat ? stat_word : 24'h00_0000;

   // power-on pin sync; second and third flops must agree
   // the first flop may be metastable, so nothing but the second reads it
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         pwr_q1 <= 1'b0;
         pwr_q2 <= 1'b0;
         pwr_q3 <= 1'b0;
      end
      else
      begin
         pwr_q1 <= power_on;
         pwr_q2 <= pwr_q1;
         pwr_q3 <= pwr_q2;
      end
   end

   // stored words; reset here models power loss, words are nonvolatile
   // no erase cycle is modelled; a write lands in one clock
   always_ff @(posedge sys_clk)
   begin
      if (wr_ok && hit_cfg)
         cfg_word <= wdata;
      if (wr_ok && hit_out)
         out_word <= wdata;
   end

   // programmed flags survive reset like the stored words
   // nothing clears them: erasing storage lies outside this block
   always_ff @(posedge sys_clk)
   begin
      if (wr_ok && hit_cfg)
      begin
         upper_set <= 1'b1;
         lower_set <= 1'b1;
      end
   end

   // lockout arms at the power-up event only if the bit was already stored
   // waiting for the power-up event keeps a fresh write from locking at once
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         lock_armed <= 1'b0;
         pwr_seen <= 1'b0;
      end
      else if (pwr_up_edge)
      begin
         pwr_seen <= 1'b1;
         lock_armed <= lock_bit;
      end
   end

   // calibration sequencer
   // runs once per power-up; RUN holds until the next reset
   always_comb
   begin
      next_state = state;
      unique case (state)
         sclk_pkg::SCLK_IDLE: if (pwr_up_edge) next_state = sclk_pkg::SCLK_CAL;
         sclk_pkg::SCLK_CAL: next_state = sclk_pkg::SCLK_RUN;
         sclk_pkg::SCLK_RUN: next_state = sclk_pkg::SCLK_RUN;
      endcase
   end

   // sequencer state register
   always_ff @(posedge sys_clk)
   begin
      if (reset)
         state <= sclk_pkg::SCLK_IDLE;
      else
         state <= next_state;
   end

   // outputs, all registered
   // decoded values lag the stored word by one clock
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         rdata <= 24'h00_0000;
         bandwidth_hz <= 16'h0000;
         update_rate_khz <= 5'h00;
         pwm_mode <= 1'b0;
         upper_clip_limit <= 12'h000;
         lower_clip_limit <= 12'h000;
         duty_midpoint <= `SCLK_MID_SCALE;
         cal_done <= 1'b0;
         lock_active <= 1'b0;
         access_rejected <= 1'b0;
      end
      else
      begin
         rdata <= next_rdata;
         bandwidth_hz <= bw_hz(bw_code);
         update_rate_khz <= rate_khz(bw_code);
         pwm_mode <= mode_bit;
         upper_clip_limit <= next_upper;
         lower_clip_limit <= next_lower;
         lock_active <= lock_armed;
         access_rejected <= lock_active && (wr_stb || rd_stb);
         if (state == sclk_pkg::SCLK_CAL)
         begin
            if (cal_en && pwm_mode)
            begin
               duty_midpoint <= cal_mid;
            end
            cal_done <= cal_en && pwm_mode;
         end
      end
   end

   // lockout and bus path; a refused access must leave no trace
   chk_lock_blocks_wr: assert property (@(posedge sys_clk) disable iff (reset)
      lock_active && wr_stb && hit_cfg |=> cfg_word == $past(cfg_word))
      else $error("write passed while locked");
   chk_lock_blocks_rd: assert property (@(posedge sys_clk) disable iff (reset)
      lock_active && rd_stb |=> rdata == 24'h00_0000)
      else $error("read passed while locked");
   chk_reject_pulse: assert property (@(posedge sys_clk) disable iff (reset)
      lock_active && (wr_stb || rd_stb) |=> access_rejected)
      else $error("refused strobe not reported");
   chk_no_false_reject: assert property (@(posedge sys_clk) disable iff (reset)
      !lock_active |=> !access_rejected)
      else $error("reject pulse without lock");
   chk_rd_cfg_data: assert property (@(posedge sys_clk) disable iff (reset)
      rd_stb && hit_cfg && !lock_active |=> rdata == $past(cfg_word))
      else $error("config read data wrong");
   // read data stand one cycle only, so a stale word cannot be mistaken
   chk_rd_idle_zero: assert property (@(posedge sys_clk) disable iff (reset)
      !rd_stb |=> rdata == 24'h00_0000)
      else $error("read data outside read cycle");

   // power-up steps: settled pin event, one calibration cycle, then run
   sequence seq_power_event;
      pwr_up_edge;
   endsequence

   sequence seq_cal_then_run;
      state == sclk_pkg::SCLK_CAL ##1 state == sclk_pkg::SCLK_RUN;
   endsequence

   chk_power_up_steps: assert property (@(posedge sys_clk) disable iff (reset)
      seq_power_event |=> seq_cal_then_run)
      else $error("power-up steps out of order");
   // the lock may arm only at the power-up event
   chk_lock_needs_cycle: assert property (@(posedge sys_clk) disable iff (reset)
      !pwr_up_edge && !lock_armed |=> !lock_armed)
      else $error("lock armed without power cycle");
   chk_lock_arms_once: assert property (@(posedge sys_clk) disable iff (reset)
      seq_power_event |=> lock_armed == $past(lock_bit))
      else $error("lock not taken from stored bit");
   chk_lock_follows: assert property (@(posedge sys_clk) disable iff (reset)
      lock_armed |=> lock_active)
      else $error("armed lock not active");

   // decode of the bandwidth code into filter point and update rate, and of the mode bit
   chk_bw_decode: assert property (@(posedge sys_clk) disable iff (reset)
      bw_code == 3'h1 |=> bandwidth_hz == 16'h0FA0)
      else $error("bandwidth decode wrong");
   chk_rate_decode: assert property (@(posedge sys_clk) disable iff (reset)
      bw_code == 3'h5 |=> update_rate_khz == 5'h01)
      else $error("update rate decode wrong");
   chk_mode_follow: assert property (@(posedge sys_clk) disable iff (reset)
      1'b1 |=> pwm_mode == $past(mode_bit))
      else $error("mode bit not followed");

   // calibration gate and result
   chk_cal_mode_gate: assert property (@(posedge sys_clk) disable iff (reset)
      state == sclk_pkg::SCLK_CAL && !pwm_mode |=> !cal_done)
      else $error("calibration without pwm mode");
   chk_cal_result: assert property (@(posedge sys_clk) disable iff (reset)
      state == sclk_pkg::SCLK_CAL && cal_en && pwm_mode |=> cal_done ##0
      duty_midpoint == $past(cal_mid))
      else $error("midpoint not computed");
   chk_cal_skip: assert property (@(posedge sys_clk) disable iff (reset)
      state == sclk_pkg::SCLK_CAL && !cal_en |=>
      !cal_done && duty_midpoint == $past(duty_midpoint))
      else $error("calibration ran while disabled");

   // clip limits: extremes, factory fallback and monotonic steps
   chk_upper_extreme: assert property (@(posedge sys_clk) disable iff (reset)
      upper_set && clph == 6'h00 |=> upper_clip_limit == `SCLK_UPPER_MAX)
      else $error("upper clip extreme wrong");
   chk_lower_extreme: assert property (@(posedge sys_clk) disable iff (reset)
      lower_set && clpl == 6'h00 |=> lower_clip_limit == `SCLK_LOWER_MIN)
      else $error("lower clip extreme wrong");
   chk_clip_default: assert property (@(posedge sys_clk) disable iff (reset)
      !upper_set |=> upper_clip_limit == `SCLK_FACT_UPPER)
      else $error("factory default not used");
   chk_lower_default: assert property (@(posedge sys_clk) disable iff (reset)
      !lower_set |=> lower_clip_limit == `SCLK_FACT_LOWER)
      else $error("factory lower default not used");
   // one code step must always move the limit the same way
   chk_clip_mono: assert property (@(posedge sys_clk) disable iff (reset)
      upper_set && clph != 6'h3F |-> next_upper > (`SCLK_UPPER_MAX -
      clip_off(clph + 6'h01, `SCLK_UPPER_STEP)))
      else $error("clip not monotonic");
   chk_lower_mono: assert property (@(posedge sys_clk) disable iff (reset)
      lower_set && clpl != 6'h3F |-> next_lower < (`SCLK_LOWER_MIN +
      clip_off(clpl + 6'h01, `SCLK_LOWER_STEP)))
      else $error("lower clip not monotonic");
endmodule : sclk_top
`default_nettype wire

/* File: hw/sclk_consts.svh */
// constants for the sensor output configuration and lock block
// Overview of operation
// - bandwidth code sets filter 3-dB point: 2000,4000,2000,1000,500,250 Hz.
// - same code sets update rate: 8,16,8,4,2,1 kHz; 110/111 not recommended.
// - calibration enable computes 50% duty midpoint at power-on; skipped when zero.
// - duty calibration acts only when output mode selects PWM.
// - upper clip code 000000 gives maximum upper limit, 111111 the minimum.
// - lower clip code 000000 gives minimum lower limit, 111111 the maximum.
// - unprogrammed clip code falls back to factory default clip limit.
// - active lockout rejects every programmer read and write.
// - lockout becomes active only after a power cycle following its write.
// - bit 3 of word 0x1C selects output mode: 0 SENT, 1 PWM.
`ifndef SCLK_CONSTS_SVH
`define SCLK_CONSTS_SVH
`define SCLK_ADDR_CFG 8'h1C
`define SCLK_ADDR_OUT 8'h1E
`define SCLK_ADDR_STAT 8'h20
`define SCLK_BW_LSB 0
`define SCLK_MODE_BIT 3
`define SCLK_CLPL_LSB 12
`define SCLK_CLPH_LSB 18
`define SCLK_CAL_BIT 3
`define SCLK_LOCK_BIT 23
`define SCLK_FULL_SCALE 12'hFFF
`define SCLK_MID_SCALE 12'h800
`define SCLK_UPPER_MAX 12'hFFF
`define SCLK_UPPER_STEP 12'h0010
`define SCLK_LOWER_MIN 12'h000
`define SCLK_LOWER_STEP 12'h0010
`define SCLK_FACT_UPPER 12'hF00
`define SCLK_FACT_LOWER 12'h100
`define SCLK_SYS_MHZ 100
`define SCLK_BLANK_WORD 24'h00_0000
`endif

/* File: hw/sclk_pkg.sv */
// types for the sensor output configuration and lock block
`default_nettype none
package sclk_pkg;
   typedef enum logic [1:0] {SCLK_IDLE, SCLK_CAL, SCLK_RUN} sclk_state_type;
endpackage : sclk_pkg
`default_nettype wire

/* File: dv/sclk_tb.sv */
// self-checking bench for the sensor output configuration and lock block
`include "sclk_consts.svh"
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk, reset, power_on, wr_stb, rd_stb;
   logic [7:0] addr;
   logic [23:0] wdata, rdata;
   logic [15:0] bandwidth_hz;
   logic [4:0] update_rate_khz;
   logic [11:0] upper_clip_limit, lower_clip_limit, duty_midpoint, up_e, lo_e;
   logic pwm_mode, cal_done, lock_active, access_rejected;
   int n_mismatch = 0;
   int comparisons = 0;
   logic [15:0] bw_e [8] = '{16'h07D0, 16'h0FA0, 16'h07D0, 16'h03E8, 16'h01F4, 16'h00FA,
      16'h07D0, 16'h07D0};
   logic [4:0] rate_e [8] = '{5'h08, 5'h10, 5'h08, 5'h04, 5'h02, 5'h01, 5'h08, 5'h08};
   logic [5:0] codes [3] = '{6'h00, 6'h3F, 6'h05};
   sclk_top u_sclk_top (.sys_clk(sys_clk), .reset(reset), .power_on(power_on), .addr(addr),
      .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
      .bandwidth_hz(bandwidth_hz), .update_rate_khz(update_rate_khz), .pwm_mode(pwm_mode),
      .upper_clip_limit(upper_clip_limit), .lower_clip_limit(lower_clip_limit),
      .duty_midpoint(duty_midpoint), .cal_done(cal_done), .lock_active(lock_active),
      .access_rejected(access_rejected));
   // 100 MHz system clock
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
      comparisons++;
      if (got !== exp)
      begin
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
         n_mismatch++;
      end
   endtask : chk
   // one-cycle write strobe, returns just after the taking edge
   task automatic wr(input logic [7:0] a, input logic [23:0] d);
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge sys_clk);
      wr_stb <= 1'b0;
   endtask : wr
   // read data stand only in the cycle after the strobe, so sample there
   task automatic rd(input logic [7:0] a, input logic [23:0] exp, input string name);
      @(posedge sys_clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge sys_clk);
      rd_stb <= 1'b0;
      #1;
      chk(name, exp, rdata);
   endtask : rd
   // decoded outputs follow one edge after the word is stored
   task automatic settle();
      @(posedge sys_clk);
      #1;
   endtask : settle
   // supply removal is modelled by reset; power-up event needs power_on high after reset release
   task automatic power_cycle();
      @(posedge sys_clk);
      reset <= 1'b1;
      power_on <= 1'b0;
      repeat (8) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      power_on <= 1'b1;
      repeat (12) @(posedge sys_clk);
      #1;
   endtask : power_cycle
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : tally_and_finish
   // watchdog far beyond the fewer than two hundred cycles the tests need
   initial
   begin
      #200000;
      n_mismatch++;
      tally_and_finish();
   end
   initial
   begin
      reset = 1'b1;
      power_on = 1'b0;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      addr = 8'h00;
      wdata = 24'h00_0000;
      power_cycle();
      chk("upper factory", `SCLK_FACT_UPPER, upper_clip_limit);
      chk("lower factory", `SCLK_FACT_LOWER, lower_clip_limit);
      $display("test factory defaults done");
      for (int i = 0; i < 8; i++)
      begin
         wr(`SCLK_ADDR_CFG, {21'h00_0000, i[2:0]});
         settle();
         chk("bandwidth", bw_e[i], bandwidth_hz);
         chk("update rate", rate_e[i], update_rate_khz);
      end
      $display("test bandwidth table done");
      foreach (codes[i])
      begin
         wr(`SCLK_ADDR_CFG, {codes[i], codes[2 - i], 8'h00, 1'b1, 3'h0});
         settle();
         up_e = `SCLK_UPPER_MAX - codes[i] * `SCLK_UPPER_STEP;
         lo_e = `SCLK_LOWER_MIN + codes[2 - i] * `SCLK_LOWER_STEP;
         chk("upper clip", up_e, upper_clip_limit);
         chk("lower clip", lo_e, lower_clip_limit);
         chk("mode", 1'b1, pwm_mode);
         rd(`SCLK_ADDR_CFG, {codes[i], codes[2 - i], 12'h008}, "cfg word");
      end
      rd(8'h05, 24'h00_0000, "unmapped");
      $display("test clip codes done");
      // last word: upper code 05, lower 00, pwm mode
      wr(`SCLK_ADDR_OUT, 24'h00_0008);
      power_cycle();
      chk("cal done", 1'b1, cal_done);
      chk("midpoint", lo_e + (up_e - lo_e) / 2, duty_midpoint);
      wr(`SCLK_ADDR_CFG, 24'h00_0000);
      power_cycle();
      chk("cal in sent", 1'b0, cal_done);
      chk("midpoint sent", `SCLK_MID_SCALE, duty_midpoint);
      $display("test calibration done");
      wr(`SCLK_ADDR_OUT, 24'h80_0000);
      rd(`SCLK_ADDR_OUT, 24'h80_0000, "lock word");
      chk("rd accepted", 1'b0, access_rejected);
      rd(`SCLK_ADDR_STAT, 24'h00_0003, "status unlocked");
      chk("lock early", 1'b0, lock_active);
      power_cycle();
      chk("lock active", 1'b1, lock_active);
      wr(`SCLK_ADDR_CFG, 24'h00_0001);
      #1;
      chk("wr rejected", 1'b1, access_rejected);
      settle();
      chk("bw kept", 16'h07D0, bandwidth_hz);
      rd(`SCLK_ADDR_OUT, 24'h00_0000, "locked read");
      chk("rd rejected", 1'b1, access_rejected);
      $display("test lockout done");
      tally_and_finish();
   end
endmodule : tb
`default_nettype wire
